// ==== tct_pkg.sv ====
// constants, field layouts and carrier types of the triple counter/timer block
// assumes a byte-wide host port with a two-bit offset and a board of four counter chips
// Notes on behaviour
// - three independent 16-bit counters per chip, each with its own state.
// - each counter takes its own mode from a control word aimed at it.
// - offsets 0 to 2 reach counter data bytes, offset 3 takes control.
// - control bits 7:6 pick the counter; code 11 is illegal and ignored.
// - control bits 5:4 pick latch, low byte only, high byte only, both.
// - two-byte access carries low byte first, then high, both directions.
// - control bits 3:1 pick mode; top bit ignored for modes 2 and 3.
// - control bit 0 picks binary or four-digit decimal counting.
// - binary spans 0 to 65535, decimal 0 to 9999, digits kept 0 to 9.
// - modes are terminal count, one-shot, rate, square wave, soft and hard strobe.
// - exactly one of the four chips answers all four locations at a time.
// - high request from inverted counter six, low from counter twelve or external.
package tct_pkg;
	localparam int NUM_CHIPS = 4;
	localparam int CNT_PER_CHIP = 3;
	localparam int NUM_CNT = NUM_CHIPS * CNT_PER_CHIP;
	localparam logic [3:0] CNT_PER_CHIP_W = 4'h3;
	localparam int IRQ_HIGH_CNT = 5;
	localparam int IRQ_LOW_CNT = 11;

	// host port offsets
	localparam logic [1:0] OFS_CNT0 = 2'h0;
	localparam logic [1:0] OFS_CTRL = 2'h3;

	// control byte field positions
	localparam int CW_SEL_HI = 7;
	localparam int CW_SEL_LO = 6;
	localparam int CW_FMT_HI = 5;
	localparam int CW_FMT_LO = 4;
	localparam int CW_MODE_HI = 3;
	localparam int CW_MODE_LO = 1;
	localparam int CW_BCD = 0;
	localparam int MODE_PERIODIC_BIT = 1;

	localparam logic [1:0] SEL_ILLEGAL = 2'h3;
	localparam logic [1:0] FMT_LATCH = 2'h0;
	localparam logic [1:0] FMT_LOW = 2'h1;
	localparam logic [1:0] FMT_HIGH = 2'h2;
	localparam logic [1:0] FMT_BOTH = 2'h3;

	localparam logic [2:0] MODE_TC = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SW_STROBE = 3'h4;
	localparam logic [2:0] MODE_HW_STROBE = 3'h5;

	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [3:0] BCD_DIGIT_ZERO = 4'h0;
	localparam logic [3:0] BCD_DIGIT_ONE = 4'h1;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef struct packed {
		logic [2:0] mode;
		logic bcd;
	} tct_cfg_t;

	// host-facing state of one counter
	typedef struct packed {
		logic [1:0] fmt;
		tct_cfg_t cfg;
		logic wr_high_next;
		logic rd_high_next;
		logic latched;
		logic [15:0] latch_val;
		logic [7:0] low_hold;
	} tct_host_t;

	// counting engine state of one counter
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic out;
		logic running;
		logic armed;
		logic clk_d;
		logic gate_d;
	} tct_eng_t;

	localparam tct_host_t HOST_RESET = '{fmt: FMT_LATCH, cfg: '{mode: MODE_TC, bcd: 1'b0},
		wr_high_next: 1'b0, rd_high_next: 1'b0, latched: 1'b0, latch_val: COUNT_ZERO, low_hold: BYTE_ZERO};
	localparam tct_eng_t ENG_RESET = '{count: COUNT_ZERO, reload: COUNT_ZERO, out: 1'b1,
		running: 1'b0, armed: 1'b0, clk_d: 1'b0, gate_d: 1'b0};
endpackage

// ==== tct_channel.sv ====
// counting engine of one 16-bit counter: decrement, reload and output waveform
// assumes counter clock and gate are synchronous to clk and slower than clk/2
`timescale 1ns/1ps
module tct_channel
	import tct_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input tct_cfg_t cfg,
	input wire logic cfg_wr,
	input wire logic load_wr,
	input wire logic [15:0] load_val,
	input wire logic cnt_clk,
	input wire logic cnt_gate,
	output logic [15:0] count,
	output logic out
);
	tct_eng_t s;
	tct_eng_t next_s;

	// one step down; decimal borrows digit by digit so 0000 wraps to 9999
	function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic borrow;
		r = v;
		borrow = 1'b1;
		if (!bcd) begin
			r = v - COUNT_ONE;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (borrow) begin
					if (r[i*4 +: 4] == BCD_DIGIT_ZERO) begin
						r[i*4 +: 4] = BCD_DIGIT_MAX;
					end else begin
						r[i*4 +: 4] = r[i*4 +: 4] - BCD_DIGIT_ONE;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// a loaded decimal digit above nine is cut to nine so decimal counting starts in range
	function automatic logic [15:0] clamp_count(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		r = v;
		if (bcd) begin
			for (int i = 0; i < 4; i++) begin
				if (r[i*4 +: 4] > BCD_DIGIT_MAX) begin
					r[i*4 +: 4] = BCD_DIGIT_MAX;
				end
			end
		end
		return r;
	endfunction

	logic tick;
	logic trig;
	logic gate_free;
	logic [15:0] nxt;

	// waveform per mode; square wave compares against half the binary reload,
	// so in decimal counting its duty cycle is only approximate
	always_comb begin
		next_s = s;
		tick = cnt_clk & ~s.clk_d;
		trig = cnt_gate & ~s.gate_d;
		gate_free = (cfg.mode == MODE_ONESHOT) || (cfg.mode == MODE_HW_STROBE);
		nxt = dec_count(s.count, cfg.bcd);
		next_s.clk_d = cnt_clk;
		next_s.gate_d = cnt_gate;
		if (cfg_wr) begin
			next_s.running = 1'b0;
			next_s.armed = 1'b0;
			next_s.out = (cfg.mode != MODE_TC);
		end else if (load_wr) begin
			next_s.reload = clamp_count(load_val, cfg.bcd);
			next_s.count = clamp_count(load_val, cfg.bcd);
			next_s.out = (cfg.mode != MODE_TC);
			next_s.running = !gate_free;
			next_s.armed = gate_free;
		end else if (s.armed && trig) begin
			next_s.count = s.reload;
			next_s.running = 1'b1;
			next_s.out = (cfg.mode != MODE_ONESHOT);
		end else if (tick && s.running && (cnt_gate || gate_free)) begin
			next_s.count = nxt;
			case (cfg.mode)
				MODE_TC, MODE_ONESHOT: begin
					if (nxt == COUNT_ZERO) begin
						next_s.out = 1'b1;
					end
				end
				MODE_RATE: begin
					if (s.count == COUNT_ONE) begin
						next_s.count = s.reload;
						next_s.out = 1'b1;
					end else if (nxt == COUNT_ONE) begin
						next_s.out = 1'b0;
					end
				end
				MODE_SQUARE: begin
					if (s.count == COUNT_ONE) begin
						next_s.count = s.reload;
						next_s.out = 1'b1;
					end else begin
						next_s.out = (nxt > {1'b0, s.reload[15:1]});
					end
				end
				MODE_SW_STROBE, MODE_HW_STROBE: begin
					if (s.count == COUNT_ZERO) begin
						next_s.out = 1'b1;
						next_s.running = 1'b0;
						next_s.count = s.count;
					end else if (nxt == COUNT_ZERO) begin
						next_s.out = 1'b0;
					end
				end
				default: begin
					next_s.out = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= ENG_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.count;
	assign out = s.out;
endmodule

// ==== tct_top.sv ====
// board of four triple counter chips behind one four-byte host window
// assumes host strobes are one cycle wide and synchronous to clk; chip_sel holds 0..3 for chips 1..4
`timescale 1ns/1ps
module tct_top
	import tct_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] chip_sel,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [1:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	input wire logic [NUM_CNT-1:0] cnt_clk,
	input wire logic [NUM_CNT-1:0] cnt_gate,
	input wire logic ext_irq,
	output logic [NUM_CNT-1:0] cnt_out,
	output logic irq_high,
	output logic irq_low
);
	typedef struct packed {
		tct_host_t [NUM_CNT-1:0] host;
		logic [7:0] rd_data;
		logic [NUM_CNT-1:0] cnt_out;
		logic irq_high;
		logic irq_low;
	} tct_top_t;

	tct_top_t s;
	tct_top_t next_s;
	logic rst_meta_n;
	logic rst_n;

	logic [NUM_CNT-1:0] cfg_wr;
	logic [NUM_CNT-1:0] load_wr;
	logic [NUM_CNT-1:0][15:0] load_val;
	logic [NUM_CNT-1:0][15:0] eng_count;
	logic [NUM_CNT-1:0] eng_out;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// one engine per counter, twelve on the board; each takes the config being written
	// so a control write sets the idle output of the new mode, not of the old one
	for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
		tct_channel u_chan (
			.clk(clk),
			.rst_n(rst_n),
			.cfg(next_s.host[g].cfg),
			.cfg_wr(cfg_wr[g]),
			.load_wr(load_wr[g]),
			.load_val(load_val[g]),
			.cnt_clk(cnt_clk[g]),
			.cnt_gate(cnt_gate[g]),
			.count(eng_count[g]),
			.out(eng_out[g])
		);
	end

	logic [3:0] base;
	logic [3:0] tgt;
	logic [1:0] sel;
	logic [1:0] fmt;
	logic [2:0] raw_mode;
	logic [15:0] src;
	tct_host_t h;

	// host port decode, access sequencing and read mux
	always_comb begin
		next_s = s;
		cfg_wr = '0;
		load_wr = '0;
		load_val = '0;
		src = COUNT_ZERO;
		base = 4'(chip_sel) * CNT_PER_CHIP_W;
		sel = wr_data[CW_SEL_HI:CW_SEL_LO];
		fmt = wr_data[CW_FMT_HI:CW_FMT_LO];
		raw_mode = wr_data[CW_MODE_HI:CW_MODE_LO];
		tgt = base + 4'(addr);
		h = s.host[tgt];

		// board outputs and interrupt requests follow the engines by one cycle
		next_s.cnt_out = eng_out;
		next_s.irq_high = ~eng_out[IRQ_HIGH_CNT];
		next_s.irq_low = eng_out[IRQ_LOW_CNT] | ext_irq;

		if (wr_en) begin
			if (addr == OFS_CTRL) begin
				tgt = base + 4'(sel);
				h = s.host[tgt];
				if (sel != SEL_ILLEGAL) begin
					if (fmt == FMT_LATCH) begin
						// a second latch before the held value is read is ignored
						if (!h.latched) begin
							h.latched = 1'b1;
							h.latch_val = eng_count[tgt];
							h.rd_high_next = 1'b0;
						end
					end else begin
						h.fmt = fmt;
						h.cfg.mode = raw_mode[MODE_PERIODIC_BIT] ? {1'b0, raw_mode[1:0]} : raw_mode;
						h.cfg.bcd = wr_data[CW_BCD];
						h.wr_high_next = 1'b0;
						h.rd_high_next = 1'b0;
						h.latched = 1'b0;
						cfg_wr[tgt] = 1'b1;
					end
					next_s.host[tgt] = h;
				end
			end else begin
				// an unconfigured counter still holds the latch code and ignores data
				case (h.fmt)
					FMT_LOW: begin
						load_wr[tgt] = 1'b1;
						load_val[tgt] = {BYTE_ZERO, wr_data};
					end
					FMT_HIGH: begin
						load_wr[tgt] = 1'b1;
						load_val[tgt] = {wr_data, BYTE_ZERO};
					end
					FMT_BOTH: begin
						if (!h.wr_high_next) begin
							h.low_hold = wr_data;
							h.wr_high_next = 1'b1;
						end else begin
							load_wr[tgt] = 1'b1;
							load_val[tgt] = {wr_data, h.low_hold};
							h.wr_high_next = 1'b0;
						end
					end
					default: begin
						h.wr_high_next = 1'b0;
					end
				endcase
				next_s.host[tgt] = h;
			end
		end

		if (rd_en) begin
			next_s.rd_data = BYTE_ZERO;
			if (addr != OFS_CTRL) begin
				tgt = base + 4'(addr);
				h = next_s.host[tgt];
				src = h.latched ? h.latch_val : eng_count[tgt];
				case (h.fmt)
					FMT_LOW: begin
						next_s.rd_data = src[7:0];
						h.latched = 1'b0;
					end
					FMT_HIGH: begin
						next_s.rd_data = src[15:8];
						h.latched = 1'b0;
					end
					FMT_BOTH: begin
						if (!h.rd_high_next) begin
							next_s.rd_data = src[7:0];
							h.rd_high_next = 1'b1;
						end else begin
							next_s.rd_data = src[15:8];
							h.rd_high_next = 1'b0;
							h.latched = 1'b0;
						end
					end
					default: begin
						next_s.rd_data = BYTE_ZERO;
					end
				endcase
				next_s.host[tgt] = h;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				s.host[i] <= HOST_RESET;
			end
			s.rd_data <= BYTE_ZERO;
			s.cnt_out <= '1;
			s.irq_high <= 1'b0;
			s.irq_low <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;
	assign cnt_out = s.cnt_out;
	assign irq_high = s.irq_high;
	assign irq_low = s.irq_low;
endmodule

// ==== tct_checker.sv ====
// checker of the counter board host port and request lines
// assumes it is bound to tct_top and sees only its ports
`timescale 1ns/1ps
module tct_checker
	import tct_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] chip_sel,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [1:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic [NUM_CNT-1:0] cnt_clk,
	input wire logic [NUM_CNT-1:0] cnt_gate,
	input wire logic ext_irq,
	input wire logic [NUM_CNT-1:0] cnt_out,
	input wire logic irq_high,
	input wire logic irq_low
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// host idle or only an illegal control byte, and no counter clock edge
	sequence s_calm;
		(!wr_en || (addr == OFS_CTRL && wr_data[7:6] == SEL_ILLEGAL)) && cnt_clk == '0 && $stable(cnt_gate);
	endsequence
	// mode 0 control byte aimed at counter zero of the first chip
	sequence s_tc_ctrl;
		wr_en && addr == OFS_CTRL && chip_sel == 2'h0 && wr_data[7:4] == {2'h0, FMT_BOTH} && wr_data[3:1] == MODE_TC;
	endsequence

	property p_irq_high; irq_high == !cnt_out[IRQ_HIGH_CNT]; endproperty
	property p_irq_low; irq_low == (cnt_out[IRQ_LOW_CNT] || $past(ext_irq)); endproperty
	property p_ext_irq; $rose(ext_irq) |=> irq_low; endproperty
	property p_ctrl_rd; rd_en && addr == OFS_CTRL |=> rd_data == 8'h00; endproperty
	property p_rd_hold; !rd_en |=> $stable(rd_data); endproperty
	property p_calm; s_calm [*4] |-> $stable(cnt_out); endproperty
	property p_tc_low; s_tc_ctrl |-> ##[1:3] !cnt_out[0]; endproperty
	property p_reset_idle; $rose(rst_b) |-> (cnt_out == '1 && rd_data == 8'h00) [*2]; endproperty

	a_irq_high: assert property (p_irq_high) else $error("high request not inverse of counter six");
	a_irq_low: assert property (p_irq_low) else $error("low request wrong");
	a_ext_irq: assert property (p_ext_irq) else $error("external request not passed");
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control offset read not zero");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
	a_calm: assert property (p_calm) else $error("counter output moved while idle");
	a_tc_low: assert property (p_tc_low) else $error("mode 0 output not low");
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
endmodule

bind tct_top tct_checker u_tct_checker (.clk(clk), .rst_b(rst_b), .chip_sel(chip_sel), .wr_en(wr_en),
	.rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate),
	.ext_irq(ext_irq), .cnt_out(cnt_out), .irq_high(irq_high), .irq_low(irq_low));

// ==== tct_host.sv ====
// host model: byte-wide strobed port master of the counter board
// assumes strobes launch on the falling edge and are taken at the next rising edge
`timescale 1ns/1ps
module tct_host
	import tct_pkg::*;
(
	input wire logic clk,
	output logic [1:0] chip_sel,
	output logic wr_en,
	output logic rd_en,
	output logic [1:0] addr,
	output logic [7:0] wr_data
);
	// idle port at time zero
	initial begin
		chip_sel = 2'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 2'h0;
		wr_data = 8'h00;
	end

	// active chip chosen before any counter access
	task automatic pick(input logic [1:0] c);
		@(negedge clk);
		chip_sel = c;
	endtask

	// one strobe per byte; data inverted once released so nothing stale shows
	task automatic put(input logic [1:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		wr_data = ~d;
	endtask

	task automatic get(input logic [1:0] a);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
	endtask

	// control byte first, then the count low byte before high byte
	task automatic setup(input logic [7:0] cw, input logic [15:0] v);
		put(OFS_CTRL, cw);
		put(cw[7:6], v[7:0]);
		put(cw[7:6], v[15:8]);
	endtask
endmodule

// ==== triple_counter_timer_control_tb_top.sv ====
// self-checking bench of the counter board: host model, counter clocks, read scoreboard
// assumes tct_checker is bound to tct_top from its own file
`timescale 1ns/1ps
module triple_counter_timer_control_tb_top
	import tct_pkg::*;
;
	logic clk;
	logic rst_b;
	logic ext_irq;
	logic [1:0] chip_sel;
	logic [1:0] addr;
	logic wr_en;
	logic rd_en;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [NUM_CNT-1:0] cnt_clk;
	logic [NUM_CNT-1:0] cnt_gate;
	logic [NUM_CNT-1:0] cnt_out;
	logic irq_high;
	logic irq_low;
	logic [7:0] exp_q[$];
	logic [15:0] v;
	logic [15:0] e;
	int fail_count;
	int checks;
	int k;

	tct_top u_tct_top (.clk(clk), .rst_b(rst_b), .chip_sel(chip_sel), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wr_data(wr_data), .rd_data(rd_data), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate),
		.ext_irq(ext_irq), .cnt_out(cnt_out), .irq_high(irq_high), .irq_low(irq_low));
	tct_host u_tct_host (.clk(clk), .chip_sel(chip_sel), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// each read answer is taken one edge after its strobe, oldest note first
	always @(posedge clk) begin
		if (rd_en === 1'b1) begin
			@(negedge clk);
			chk(16'(rd_data), 16'(exp_q.pop_front()));
		end
	end

	task automatic rd(input logic [1:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		u_tct_host.get(a);
	endtask

	// one counter clock pulse, then room for engine and output registers
	task automatic tick(input int n);
		@(negedge clk);
		cnt_clk[n] = 1'b1;
		@(negedge clk);
		cnt_clk[n] = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		fail_count++;
		report_and_stop;
	end

	initial begin
		rst_b = 1'b0;
		cnt_clk = '0;
		cnt_gate = '1;
		ext_irq = 1'b0;
		k = $urandom(32'hD6E8);
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		rd(OFS_CNT0, 8'h00);
		rd(OFS_CTRL, 8'h00);
		$display("test reset reads done");
		// every counter of every chip: load, count, latch, count on, read back
		for (int c = 0; c < NUM_CHIPS; c++) begin
			u_tct_host.pick(c[1:0]);
			for (int ch = 0; ch < CNT_PER_CHIP; ch++) begin
				v = 16'($urandom) | 16'h0100;
				k = $urandom_range(3, 1);
				ext_irq = 1'($urandom);
				u_tct_host.setup({ch[1:0], FMT_BOTH, MODE_TC, 1'b0}, v);
				repeat (k) tick(c * 3 + ch);
				u_tct_host.put(OFS_CTRL, {ch[1:0], FMT_LATCH, 4'h0});
				tick(c * 3 + ch);
				e = v - 16'(k);
				rd(ch[1:0], e[7:0]);
				rd(ch[1:0], e[15:8]);
				chk(16'(cnt_out[c * 3 + ch]), 16'h0000);
			end
		end
		$display("test load latch read done");
		// counter six reaches zero: output rises and stays, high request drops
		u_tct_host.pick(2'h1);
		u_tct_host.put(OFS_CTRL, 8'h90);
		u_tct_host.put(2'h2, 8'h02);
		repeat (3) tick(IRQ_HIGH_CNT);
		chk(16'(cnt_out[IRQ_HIGH_CNT]), 16'h0001);
		chk(16'(irq_high), 16'h0000);
		$display("test terminal count done");
		// decimal count from 1000 steps to 0999, high byte only
		u_tct_host.pick(2'h0);
		u_tct_host.put(OFS_CTRL, 8'h61);
		u_tct_host.put(2'h1, 8'h10);
		tick(1);
		u_tct_host.put(OFS_CTRL, 8'h40);
		rd(2'h1, 8'h09);
		$display("test decimal done");
		// both codes of the rate mode: low at count one, high again on reload
		for (int m = 2; m < 8; m += 4) begin
			u_tct_host.setup({2'h0, FMT_BOTH, 3'(m), 1'b0}, 16'h0002);
			repeat (3) @(negedge clk);
			chk(16'(cnt_out[0]), 16'h0001);
			tick(0);
			chk(16'(cnt_out[0]), 16'h0000);
			tick(0);
			chk(16'(cnt_out[0]), 16'h0001);
		end
		// illegal counter code must leave counter zero alone
		u_tct_host.put(OFS_CTRL, 8'hF0);
		repeat (3) @(negedge clk);
		chk(16'(cnt_out[0]), 16'h0001);
		$display("test modes done");
		repeat (4) @(negedge clk);
		report_and_stop;
	end
endmodule
